// [design/smm_pkg.sv]
// Purpose: shared constants for the serial link controller
// Assumes: 200 MHz core clock, 32-bit AHB-Lite register port
// Notes:   one word per register
package smm_pkg;

  localparam int unsigned CORE_CLK_NS  = 5;
  localparam int unsigned SCLK_HALF_NS = 60;
  localparam int unsigned HALF_CYC     = (SCLK_HALF_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;

  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_OP     = 8'h04;
  localparam logic [7:0] REG_TXDATA = 8'h08;
  localparam logic [7:0] REG_RXDATA = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;

  // control fields
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_CLOCK_IDLE_LEVEL_BIT = 2;
  localparam int unsigned CTRL_CLOCK_SAMPLE_PHASE_BIT = 3;
  localparam int unsigned CTRL_ADDR_LSB = 4;
  localparam int unsigned CTRL_DIR_BIT  = 7;
  localparam logic [7:0]  CTRL_RESET    = 8'h08;

  // slave status byte fields
  localparam int unsigned ST_TXE_BIT = 3;
  localparam int unsigned ST_RXF_BIT = 2;
  localparam int unsigned ST_ACK_BIT = 1;

  // status register fields
  localparam int unsigned SR_BUSY_BIT  = 0;
  localparam int unsigned SR_OPEN_BIT  = 1;
  localparam int unsigned SR_RXV_BIT   = 2;
  localparam int unsigned SR_ERR_BIT   = 3;
  localparam int unsigned SR_SLAVE_LSB = 8;

  localparam logic [1:0] OP_OPEN  = 2'h1;
  localparam logic [1:0] OP_BYTE  = 2'h2;
  localparam logic [1:0] OP_CLOSE = 2'h3;

  typedef enum logic [1:0] {
    MODE_FULL, MODE_HALF4, MODE_HALF3, MODE_PLAIN
  } smm_mode_t;

  typedef enum logic [2:0] {
    K_CMD, K_WR, K_RD, K_STAT, K_XCH
  } smm_kind_t;

endpackage : smm_pkg

// [design/smm_host.sv]
// Purpose: master-side controller for a multimode serial slave
// Assumes: software drives byte-level operations over AHB-Lite
// Notes:   serial clock is made here by a divider of the core clock

module smm_host
  import smm_pkg::*;
#(
  parameter int unsigned HALF_CYCLES = smm_pkg::HALF_CYC
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic             o_hreadyout,
  output logic             o_hresp,
  output logic [31:0]      o_hrdata,
  output logic             o_sclk,
  output logic             o_select_n,
  output logic             o_mosi,
  output logic             o_mosi_oe_n,
  input  wire logic        i_mosi,
  input  wire logic        i_miso
);
  import smm_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_SHIFT, ST_TAIL} smm_state_t;

  smm_state_t  state_q;
  smm_kind_t   kind_q;
  smm_kind_t   kind_nx_q;
  logic        have_nx_q;
  logic [7:0]  ctrl_q;
  logic [7:0]  txdata_q;
  logic [7:0]  rx_q;
  logic        rx_valid_q;
  logic [7:0]  slave_st_q;
  logic        err_q;
  logic        open_q;
  logic        first_rd_q;
  logic [7:0]  div_q;
  logic [3:0]  edge_q;
  logic        sclk_q;
  logic        sel_n_q;
  logic        drive_q;
  logic        src_mosi_q;
  logic [7:0]  tx_sh_q;
  logic [7:0]  rx_sh_q;
  logic        miso_s1_q;
  logic        miso_s2_q;
  logic        mosi_s1_q;
  logic        mosi_s2_q;
  logic        wr_pend_q;
  logic [7:0]  wr_addr_q;
  logic [31:0] hrdata_q;

  smm_mode_t   mode;
  logic        clock_idle_level;
  logic        clock_sample_phase;
  logic        dir_rd;
  logic        ap_take;
  logic        op_go;
  logic [1:0]  op_code;
  logic        tick;
  logic        in_bit;
  logic [7:0]  rx_byte;
  logic        accept;

  assign mode    = smm_mode_t'(ctrl_q[CTRL_MODE_LSB +: 2]);
  assign clock_idle_level    = ctrl_q[CTRL_CLOCK_IDLE_LEVEL_BIT];
  assign clock_sample_phase    = ctrl_q[CTRL_CLOCK_SAMPLE_PHASE_BIT];
  assign dir_rd  = ctrl_q[CTRL_DIR_BIT];
  assign ap_take = i_hsel && i_hready && i_htrans[1];
  assign op_go   = wr_pend_q && (wr_addr_q == REG_OP);
  assign op_code = i_hwdata[1:0];
  assign tick    = (div_q == 8'(HALF_CYCLES - 1));
  assign in_bit  = src_mosi_q ? mosi_s2_q : miso_s2_q;
  assign rx_byte = clock_sample_phase ? {rx_sh_q[6:0], in_bit} : rx_sh_q;
  // slave may take data only when it acked and its receive side is free
  assign accept  = slave_st_q[ST_ACK_BIT] && !slave_st_q[ST_RXF_BIT];

  // byte sent for a given kind
  function automatic logic [7:0] out_byte(input smm_kind_t k);
    case (k)
      K_CMD:   out_byte = {ctrl_q[CTRL_ADDR_LSB +: 3], dir_rd, 4'h0};
      K_WR:    out_byte = txdata_q;
      K_XCH:   out_byte = txdata_q;
      default: out_byte = 8'h00;
    endcase
  endfunction : out_byte

  // line carries slave data back on the shared data line
  function automatic logic from_mosi(input smm_kind_t k);
    from_mosi = (mode == MODE_HALF4 || mode == MODE_HALF3) &&
                (k == K_RD || k == K_STAT);
  endfunction : from_mosi

  // received byte is a slave status byte
  function automatic logic to_status(input smm_kind_t k);
    case (k)
      K_CMD, K_WR: to_status = (mode != MODE_HALF3);
      K_STAT:      to_status = 1'b1;
      default:     to_status = 1'b0;
    endcase
  endfunction : to_status

  // two-stage sync of returning lines
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      miso_s1_q <= 1'b0;
      miso_s2_q <= 1'b0;
      mosi_s1_q <= 1'b0;
      mosi_s2_q <= 1'b0;
    end else begin
      miso_s1_q <= i_miso;
      miso_s2_q <= miso_s1_q;
      mosi_s1_q <= i_mosi;
      mosi_s2_q <= mosi_s1_q;
    end
  end

  // bus address phase and read data
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata_q  <= 32'h0000_0000;
    end else begin
      wr_pend_q <= ap_take && i_hwrite;
      if (ap_take) begin
        wr_addr_q <= i_haddr[7:0];
      end
      if (ap_take && !i_hwrite) begin
        case (i_haddr[7:0])
          REG_CTRL:   hrdata_q <= {24'h0, ctrl_q};
          REG_TXDATA: hrdata_q <= {24'h0, txdata_q};
          REG_RXDATA: hrdata_q <= {24'h0, rx_q};
          REG_STATUS: hrdata_q <= {16'h0, slave_st_q, 4'h0, err_q, rx_valid_q,
                                   open_q, (state_q != ST_IDLE)};
          default:    hrdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // software registers
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      ctrl_q   <= CTRL_RESET;
      txdata_q <= 8'h00;
    end else if (wr_pend_q) begin
      if (wr_addr_q == REG_CTRL) begin
        ctrl_q <= i_hwdata[7:0];
      end
      if (wr_addr_q == REG_TXDATA) begin
        txdata_q <= i_hwdata[7:0];
      end
    end
  end

  // receive byte valid: engine set wins over read clear
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      rx_valid_q <= 1'b0;
    end else if (state_q == ST_SHIFT && tick && edge_q == 4'hf &&
                 (kind_q == K_RD || kind_q == K_XCH)) begin
      rx_valid_q <= 1'b1;
    end else if (ap_take && !i_hwrite && i_haddr[7:0] == REG_RXDATA) begin
      rx_valid_q <= 1'b0;
    end
  end

  // sticky error: refused operation; write one to clear
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      err_q <= 1'b0;
    end else if (op_go && (state_q != ST_IDLE ||
                 (op_code == OP_OPEN && open_q) ||
                 (op_code != OP_OPEN && !open_q) ||
                 (op_code == OP_BYTE && mode != MODE_PLAIN && !dir_rd && !accept))) begin
      err_q <= 1'b1;
    end else if (wr_pend_q && wr_addr_q == REG_STATUS && i_hwdata[SR_ERR_BIT]) begin
      err_q <= 1'b0;
    end
  end

  // half period divider
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || state_q == ST_IDLE || tick) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  // transaction sequencer and shifter
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      state_q    <= ST_IDLE;
      kind_q     <= K_CMD;
      kind_nx_q  <= K_CMD;
      have_nx_q  <= 1'b0;
      open_q     <= 1'b0;
      first_rd_q <= 1'b0;
      sel_n_q    <= 1'b1;
      sclk_q     <= 1'b0;
      edge_q     <= 4'h0;
      drive_q    <= 1'b0;
      src_mosi_q <= 1'b0;
      tx_sh_q    <= 8'h00;
      rx_sh_q    <= 8'h00;
      rx_q       <= 8'h00;
      slave_st_q <= 8'h00;
    end else begin
      case (state_q)
        ST_IDLE: begin
          sclk_q <= clock_idle_level;
          if (op_go && op_code == OP_OPEN && !open_q) begin
            sel_n_q    <= 1'b0;
            open_q     <= 1'b1;
            first_rd_q <= 1'b1;
            slave_st_q <= 8'h00;
            state_q    <= ST_LEAD;
            kind_q     <= K_CMD;
            have_nx_q  <= (mode != MODE_PLAIN);
            kind_nx_q  <= K_STAT;
            if (mode != MODE_HALF3) begin
              kind_nx_q <= K_CMD;
            end
          end else if (op_go && op_code == OP_BYTE && open_q) begin
            if (mode == MODE_PLAIN) begin
              kind_q    <= K_XCH;
              have_nx_q <= 1'b0;
              state_q   <= ST_SHIFT;
            end else if (dir_rd) begin
              // full duplex: status before every data byte but the first
              kind_q     <= (mode == MODE_FULL && !first_rd_q) ? K_STAT : K_RD;
              kind_nx_q  <= K_RD;
              have_nx_q  <= (mode == MODE_FULL && !first_rd_q);
              first_rd_q <= 1'b0;
              state_q    <= ST_SHIFT;
            end else if (accept) begin
              kind_q    <= K_WR;
              kind_nx_q <= K_STAT;
              have_nx_q <= (mode == MODE_HALF3);
              state_q   <= ST_SHIFT;
            end
          end else if (op_go && op_code == OP_CLOSE && open_q) begin
            sel_n_q <= 1'b1;
            open_q  <= 1'b0;
            state_q <= ST_TAIL;
          end
          edge_q     <= 4'h0;
          drive_q    <= drive_q && !(op_go && op_code == OP_CLOSE);
          tx_sh_q    <= out_byte(op_code == OP_BYTE ? (mode == MODE_PLAIN ? K_XCH :
                        (dir_rd ? K_RD : K_WR)) : K_CMD);
          src_mosi_q <= from_mosi(op_code == OP_BYTE && dir_rd ? K_RD : K_CMD);
          if (op_go && op_code == OP_BYTE && open_q) begin
            drive_q <= !from_mosi(dir_rd && mode != MODE_PLAIN ? K_RD : K_WR);
            if (mode == MODE_FULL && dir_rd && !first_rd_q) begin
              drive_q    <= 1'b1;
              src_mosi_q <= 1'b0;
              tx_sh_q    <= 8'h00;
            end
          end
          if (op_go && op_code == OP_OPEN && !open_q) begin
            drive_q <= 1'b1;
          end
        end
        ST_LEAD: begin
          if (tick) begin
            state_q   <= have_nx_q ? ST_SHIFT : ST_IDLE;
            have_nx_q <= (mode == MODE_HALF3);
            kind_nx_q <= K_STAT;
          end
        end
        ST_SHIFT: begin
          if (tick) begin
            sclk_q <= ~sclk_q;
            edge_q <= edge_q + 4'h1;
            if (clock_sample_phase ? edge_q[0] : !edge_q[0]) begin
              rx_sh_q <= {rx_sh_q[6:0], in_bit};
            end
            if (clock_sample_phase ? (!edge_q[0] && edge_q != 4'h0) : (edge_q[0] && edge_q != 4'hf)) begin
              tx_sh_q <= {tx_sh_q[6:0], 1'b0};
            end
            if (edge_q == 4'hf) begin
              if (to_status(kind_q)) begin
                slave_st_q <= rx_byte;
              end
              if (kind_q == K_RD || kind_q == K_XCH) begin
                rx_q <= rx_byte;
              end
              if (have_nx_q) begin
                kind_q     <= kind_nx_q;
                have_nx_q  <= 1'b0;
                tx_sh_q    <= out_byte(kind_nx_q);
                src_mosi_q <= from_mosi(kind_nx_q);
                drive_q    <= !from_mosi(kind_nx_q);
                edge_q     <= 4'h0;
              end else begin
                state_q <= ST_IDLE;
              end
            end
          end
        end
        ST_TAIL: begin
          sclk_q <= clock_idle_level;
          if (tick) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;
  assign o_hrdata    = hrdata_q;
  assign o_sclk      = sclk_q;
  assign o_select_n  = sel_n_q;
  assign o_mosi      = tx_sh_q[7];
  assign o_mosi_oe_n = !(drive_q && !sel_n_q);

endmodule : smm_host

// [dv/smm_host_sva.sv]
// Purpose: port checks for smm_host
// Assumes: clock polarity held while select is high
// Notes:   bound to every smm_host
module smm_host_sva
  import smm_pkg::*;
#(
  parameter int unsigned HALF_CYCLES = 12
) (
  input wire logic        i_core_clk,
  input wire logic        i_rst_n,
  input wire logic        i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0]  i_htrans,
  input wire logic        i_hwrite,
  input wire logic [31:0] i_hwdata,
  input wire logic        i_hready,
  input wire logic        o_hreadyout,
  input wire logic        o_hresp,
  input wire logic [31:0] o_hrdata,
  input wire logic        o_sclk,
  input wire logic        o_select_n,
  input wire logic        o_mosi_oe_n
);
  logic        aph, rd, opw_q, op_open, op_close;
  logic [15:0] hc_q;
  assign aph = i_hsel && i_hready && i_htrans[1];
  assign rd = aph && !i_hwrite;
  assign op_open = opw_q && i_hwdata[1:0] == OP_OPEN;
  assign op_close = opw_q && i_hwdata[1:0] == OP_CLOSE;
  always_ff @(posedge i_core_clk) begin
    opw_q <= i_rst_n && aph && i_hwrite && i_haddr[7:0] == REG_OP;
  end
  // cycles since the last serial clock or select change
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || $changed(o_sclk) || $changed(o_select_n)) hc_q <= '0;
    else if (hc_q != 16'hffff) hc_q <= hc_q + 16'h1;
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  bus_okay_a: assert property (o_hreadyout && !o_hresp) else $error("bus not ready or not okay");
  unmapped_a: assert property (rd && (i_haddr[7:0] == REG_OP || i_haddr[7:0] > REG_STATUS)
    |=> o_hrdata == 32'h0) else $error("empty place read not zero");
  rx_upper_a: assert property (rd && i_haddr[7:0] == REG_RXDATA |=> o_hrdata[31:8] == 24'h0)
    else $error("receive word upper bits set");
  line_release_a: assert property (o_select_n |-> o_mosi_oe_n)
    else $error("data line driven while deselected");
  open_cause_a: assert property ($fell(o_select_n) |-> $past(op_open))
    else $error("select fell without open");
  close_cause_a: assert property ($rose(o_select_n) |-> $past(op_close))
    else $error("select rose without close");
  sclk_setup_a: assert property ($fell(o_select_n) |-> $stable(o_sclk) [*8])
    else $error("clock moved right after select");
  half_period_a: assert property ($changed(o_sclk) |-> hc_q >= HALF_CYCLES - 1)
    else $error("clock half period too short");
  sclk_idle_a: assert property (o_select_n && $past(o_select_n) |-> $stable(o_sclk))
    else $error("clock moved while idle");
  cover property ($fell(o_select_n));
  cover property ($rose(o_select_n));
  cover property (rd && i_haddr[7:0] == REG_RXDATA);
endmodule : smm_host_sva

bind smm_host smm_host_sva #(.HALF_CYCLES(HALF_CYCLES)) u_sva (
  .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_hsel(i_hsel), .i_haddr(i_haddr),
  .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hwdata(i_hwdata), .i_hready(i_hready),
  .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_hrdata(o_hrdata), .o_sclk(o_sclk),
  .o_select_n(o_select_n), .o_mosi_oe_n(o_mosi_oe_n));

// [dv/smm_slave_model.sv]
// Purpose: behavioural serial slave facing smm_host
// Assumes: full duplex or plain mode, clock idle low, change on rising
// Notes:   floating status bits driven low
module smm_slave_model #(
  parameter logic [2:0] ADDR = 3'd5
) (
  input  wire logic       i_clk,
  input  wire logic       i_sclk,
  input  wire logic       i_select_n,
  input  wire logic       i_mosi,
  input  wire logic       i_plain,
  input  wire logic       i_txe,
  input  wire logic       i_rxf,
  input  wire logic [7:0] i_data,
  output logic            o_miso,
  output logic [7:0]      o_cmd,
  output logic [7:0]      o_wr,
  output int              o_wr_cnt
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       sclk_q, ack_q, ack;
  logic [7:0] rx, st, tx;
  int         nb, idx;
  initial begin
    o_miso = 0; o_wr_cnt = 0; ack_q = 0; idx = 0; nb = 0; rx = 0; o_cmd = 0;
  end
  assign ack = (idx == 0) ? (rx[5:3] == ADDR) : ack_q;
  assign st = {4'h0, i_txe, i_rxf, ack, 1'b0};
  assign tx = (i_plain || (ack_q && o_cmd[4] && idx % 2 == 1)) ? i_data : st;
  always @(posedge i_clk) begin
    sclk_q <= i_sclk;
    if (i_select_n) begin
      nb = 0; idx = 0; rx = '0; ack_q <= 1'b0; o_miso <= ~o_miso;
    end else if (i_sclk && !sclk_q) begin
      o_miso <= tx[7 - nb];
    end else if (!i_sclk && sclk_q) begin
      rx = {rx[6:0], i_mosi};
      nb++;
      if (nb == 8) begin
        nb = 0;
        if (idx == 0 && !i_plain) begin
          o_cmd <= rx; ack_q <= rx[7:5] == ADDR;
        end else if (i_plain || (ack_q && !o_cmd[4])) begin
          o_wr <= rx; o_wr_cnt++;
        end
        idx++;
      end
    end
  end
endmodule : smm_slave_model

// [dv/tb.sv]
// Purpose: self-checking bench for smm_host
// Assumes: default half period, slave at address 5
// Notes:   full duplex, four-wire half duplex and plain modes exercised
module tb;
  import smm_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk, rst_n, hwrite, sclk, sel_n, mosi, oe_n, miso, mosi_w;
  logic        transmit_empty_flag, receive_full_flag, plain, hreadyout, hresp;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [7:0]  sdata, cmd, wr;
  int          wr_cnt, num_errors, n_tests;
  // released line shows the inverse of the host's current mosi output
  assign mosi_w = oe_n ? ~mosi : mosi;
  smm_host dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_hsel(1'b1), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
    .i_hready(hreadyout), .o_hreadyout(hreadyout), .o_hresp(hresp), .o_hrdata(hrdata),
    .o_sclk(sclk), .o_select_n(sel_n), .o_mosi(mosi), .o_mosi_oe_n(oe_n),
    .i_mosi(mosi_w), .i_miso(miso));
  smm_slave_model #(.ADDR(3'd5)) u_slave (.i_clk(clk), .i_sclk(sclk), .i_select_n(sel_n),
    .i_mosi(mosi_w), .i_plain(plain), .i_txe(transmit_empty_flag), .i_rxf(receive_full_flag), .i_data(sdata),
    .o_miso(miso), .o_cmd(cmd), .o_wr(wr), .o_wr_cnt(wr_cnt));
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  task automatic finish_test();
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic hwait();
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (hreadyout !== 1'b1 && k < 64);
    if (k >= 64) begin
      num_errors++;
      finish_test();
    end
  endtask : hwait
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hwait();
    htrans <= 2'h0;
    hwdata <= d;
    hwait();
    r = hrdata;
  endtask : bus
  task automatic op(input logic [1:0] c);
    int k;
    bus(1'b1, REG_OP, {30'h0, c});
    @(posedge clk);
    k = 0;
    do begin
      bus(1'b0, REG_STATUS, 32'h0);
      k++;
    end while (r[SR_BUSY_BIT] !== 1'b0 && k < 1000);
    if (k >= 1000) begin
      num_errors++;
      finish_test();
    end
  endtask : op
  task automatic t_reset();
    bus(1'b0, REG_CTRL, 32'h0);
    chk("ctrl", {24'h0, CTRL_RESET}, r);
    bus(1'b1, REG_RXDATA, 32'h5a);
    bus(1'b0, REG_RXDATA, 32'h0);
    chk("rxdata", 32'h0, r);
    bus(1'b0, 8'h14, 32'h0);
    chk("unmapped", 32'h0, r);
    chk("idle lines", 32'h6, {29'h0, sel_n, oe_n, sclk});
    $display("t_reset done");
  endtask : t_reset
  task automatic t_write();
    bus(1'b1, REG_CTRL, 32'h58);
    op(OP_OPEN);
    chk("command", 32'ha0, {24'h0, cmd});
    chk("status", 32'h5, {29'h0, r[11:9]});
    bus(1'b1, REG_TXDATA, 32'ha5);
    op(OP_BYTE);
    chk("wr byte", 32'ha5, {24'h0, wr});
    bus(1'b1, REG_TXDATA, 32'h3c);
    op(OP_BYTE);
    chk("wr count", 32'h2, wr_cnt);
    op(OP_CLOSE);
    chk("select", 32'h1, {31'h0, sel_n});
    $display("t_write done");
  endtask : t_write
  task automatic t_refuse(input logic [7:0] ctl, input logic full, input logic [2:0] st);
    receive_full_flag <= full;
    bus(1'b1, REG_CTRL, {24'h0, ctl});
    op(OP_OPEN);
    chk("refuse status", {29'h0, st}, {29'h0, r[11:9]});
    bus(1'b1, REG_TXDATA, 32'h77);
    op(OP_BYTE);
    chk("refuse err", 32'h1, {31'h0, r[SR_ERR_BIT]});
    chk("refuse count", 32'h2, wr_cnt);
    op(OP_CLOSE);
    bus(1'b1, REG_STATUS, 32'h8);
    bus(1'b0, REG_STATUS, 32'h0);
    chk("err clear", 32'h0, {31'h0, r[SR_ERR_BIT]});
    receive_full_flag <= 1'b0;
    $display("t_refuse done");
  endtask : t_refuse
  task automatic t_half4();
    bus(1'b1, REG_CTRL, 32'h59);
    op(OP_OPEN);
    chk("h4 command", 32'ha0, {24'h0, cmd});
    chk("h4 status", 32'h5, {29'h0, r[11:9]});
    bus(1'b1, REG_TXDATA, 32'h4b);
    op(OP_BYTE);
    chk("h4 wr byte", 32'h4b, {24'h0, wr});
    chk("h4 wr count", 32'h3, wr_cnt);
    op(OP_CLOSE);
    chk("h4 select", 32'h1, {31'h0, sel_n});
    $display("t_half4 done");
  endtask : t_half4
  task automatic t_read();
    transmit_empty_flag <= 1'b0;
    sdata <= 8'hc3;
    bus(1'b1, REG_CTRL, 32'hd8);
    op(OP_OPEN);
    chk("rd command", 32'hb0, {24'h0, cmd});
    chk("rd status", 32'h1, {29'h0, r[11:9]});
    op(OP_BYTE);
    chk("rx valid", 32'h1, {31'h0, r[SR_RXV_BIT]});
    bus(1'b0, REG_RXDATA, 32'h0);
    chk("rd data", 32'hc3, r);
    bus(1'b0, REG_STATUS, 32'h0);
    chk("rx valid clear", 32'h0, {31'h0, r[SR_RXV_BIT]});
    sdata <= 8'h3e;
    op(OP_BYTE);
    bus(1'b0, REG_RXDATA, 32'h0);
    chk("rd data 2", 32'h3e, r);
    op(OP_CLOSE);
    transmit_empty_flag <= 1'b1;
    $display("t_read done");
  endtask : t_read
  task automatic t_plain();
    plain <= 1'b1;
    sdata <= 8'h69;
    bus(1'b1, REG_CTRL, 32'h0b);
    bus(1'b1, REG_TXDATA, 32'h96);
    op(OP_OPEN);
    op(OP_BYTE);
    chk("plain out", 32'h96, {24'h0, wr});
    bus(1'b0, REG_RXDATA, 32'h0);
    chk("plain in", 32'h69, r);
    op(OP_CLOSE);
    plain <= 1'b0;
    $display("t_plain done");
  endtask : t_plain
  initial begin
    rst_n = 0; haddr = 0; htrans = 0; hwrite = 0; hwdata = 0;
    transmit_empty_flag = 1; receive_full_flag = 0; plain = 0; sdata = 0; num_errors = 0; n_tests = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_write();
    t_refuse(8'h58, 1'b1, 3'h7);
    t_refuse(8'h38, 1'b0, 3'h4);
    t_half4();
    t_read();
    t_plain();
    finish_test();
  end
endmodule : tb
